//--- hw/ocfd_monitor.sv
`timescale 1ns/10ps
// one oscillator watchdog: synchronises the oscillator, counts cycles with no edge
module ocfd_monitor #(
  parameter logic [7:0] TIMEOUT = 8'h08
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic osc_enable,
  input wire logic detector_enable,
  input wire logic osc_in,
  // status
  output logic fail,
  output logic stuck_high,
  output logic ready
);
  typedef enum logic [1:0] {OCFD_IDLE, OCFD_SETTLE, OCFD_WATCH, OCFD_FAILED} ocfd_mon_state_type;
  ocfd_mon_state_type state_q;
  logic sync1_q, sync2_q, last_q;
  logic [7:0] cnt_q;
  logic det_en_q;
  logic osc_en_q;
  logic edge_seen;
  assign edge_seen = sync2_q ^ last_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= osc_in;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      det_en_q <= 1'b0;
      osc_en_q <= 1'b0;
    end else begin
      det_en_q <= detector_enable;
      osc_en_q <= osc_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= OCFD_IDLE;
      cnt_q <= ocfd_pkg::CNT_RESET;
    end else begin
      case (state_q)
        OCFD_IDLE: begin
          cnt_q <= ocfd_pkg::CNT_RESET;
          if (detector_enable && !det_en_q && osc_en_q) begin
            state_q <= OCFD_FAILED; // re-arm while running misfires
          end else if (osc_enable && detector_enable) begin
            state_q <= OCFD_SETTLE;
          end
        end
        OCFD_SETTLE: begin
          if (!osc_enable || !detector_enable) begin
            state_q <= OCFD_IDLE;
          end else if (edge_seen || cnt_q == ocfd_pkg::ARM_SETTLE_CYC) begin
            state_q <= OCFD_WATCH;
            cnt_q <= ocfd_pkg::CNT_RESET;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        OCFD_WATCH: begin
          if (!osc_enable || !detector_enable) begin
            state_q <= OCFD_IDLE;
          end else if (edge_seen) begin
            cnt_q <= ocfd_pkg::CNT_RESET;
          end else if (cnt_q == TIMEOUT) begin
            state_q <= OCFD_FAILED;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        OCFD_FAILED: begin
          if (!detector_enable && !osc_enable) begin
            state_q <= OCFD_IDLE;
          end
        end
        default: state_q <= OCFD_IDLE;
      endcase
    end
  end

  // detector raised while the oscillator was already running lands in failed
  assign fail = (state_q == OCFD_FAILED);
  assign stuck_high = sync2_q;
  assign ready = osc_enable && (state_q == OCFD_WATCH || state_q == OCFD_FAILED || !detector_enable);
endmodule : ocfd_monitor

//--- hw/ocfd_pkg.sv
package ocfd_pkg;
  // clock selection codes
  localparam logic [1:0] SEL_HF = 2'h0;
  localparam logic [1:0] SEL_LF = 2'h1;
  localparam logic [1:0] SEL_SAFE = 2'h2;
  // monitor timing, in sys_clk cycles without an edge of the watched clock
  localparam logic [7:0] HF_TIMEOUT_CYC = 8'h08;
  localparam logic [7:0] LF_TIMEOUT_CYC = 8'hFF;
  // settling window after enable before a failure may be flagged
  localparam logic [7:0] ARM_SETTLE_CYC = 8'h10;
  localparam logic [7:0] CNT_RESET = 8'h00;
  // silicon revision selector: 1 means the safe switch is broken when input stuck high
  localparam logic STUCK_HIGH_SWITCH_BROKEN = 1'b1;
endpackage : ocfd_pkg

//--- hw/ocfd_top.sv
`timescale 1ns/10ps
// ==========================================================
// Functional notes
// - a failure with the input stuck high is flagged but the automatic safe switch is withheld.
// - with the fast detector enabled a failure leaves the fast ready flag at one.
// - toggling the fast detector enable while its oscillator runs may raise a false failure.
// - toggling the slow detector enable while its oscillator runs may raise a false failure.
module ocfd_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // fast oscillator control and pin
  input wire logic hf_osc_enable,
  input wire logic hf_detector_enable,
  input wire logic main_crystal_oscillator,
  // slow oscillator control and pin
  input wire logic lf_osc_enable,
  input wire logic lf_detector_enable,
  input wire logic low_freq_crystal_oscillator,
  // generator source requested by software
  input wire logic [1:0] gen_source_req,
  // status
  output logic clock_fail_flag,
  output logic clock_switched_flag,
  output logic hf_osc_fail_flag,
  output logic hf_osc_ready_flag,
  output logic lf_osc_fail_flag,
  // generator source actually used
  output logic [1:0] gen_source
);
  // ==========================================================
  // monitors
  logic hf_fail, hf_stuck, hf_ready;
  logic lf_fail, lf_stuck;

  ocfd_monitor #(.TIMEOUT(ocfd_pkg::HF_TIMEOUT_CYC)) u_hf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(hf_osc_enable),
    .detector_enable(hf_detector_enable),
    .osc_in(main_crystal_oscillator),
    .fail(hf_fail),
    .stuck_high(hf_stuck),
    .ready(hf_ready)
  );

  ocfd_monitor #(.TIMEOUT(ocfd_pkg::LF_TIMEOUT_CYC)) u_lf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(lf_osc_enable),
    .detector_enable(lf_detector_enable),
    .osc_in(low_freq_crystal_oscillator),
    .fail(lf_fail),
    .stuck_high(lf_stuck),
    .ready()
  );

  // ==========================================================
  // status flags
  logic any_fail;
  logic src_failed;
  assign any_fail = hf_fail || lf_fail;
  assign src_failed = (gen_source_req == ocfd_pkg::SEL_HF && hf_fail) ||
                      (gen_source_req == ocfd_pkg::SEL_LF && lf_fail);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clock_fail_flag <= 1'b0;
      hf_osc_fail_flag <= 1'b0;
      lf_osc_fail_flag <= 1'b0;
      hf_osc_ready_flag <= 1'b0;
    end else begin
      clock_fail_flag <= any_fail;
      hf_osc_fail_flag <= hf_fail;
      lf_osc_fail_flag <= lf_fail;
      hf_osc_ready_flag <= hf_ready; // stays one after a failure
    end
  end

  // ==========================================================
  // safe clock switch
  logic switch_blocked;
  assign switch_blocked = ocfd_pkg::STUCK_HIGH_SWITCH_BROKEN &&
                          ((gen_source_req == ocfd_pkg::SEL_HF && hf_stuck) ||
                           (gen_source_req == ocfd_pkg::SEL_LF && lf_stuck));

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clock_switched_flag <= 1'b0;
    end else if (src_failed && !switch_blocked) begin
      clock_switched_flag <= 1'b1;
    end else if (!any_fail) begin
      clock_switched_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gen_source <= ocfd_pkg::SEL_HF;
    end else if (src_failed && switch_blocked) begin
      gen_source <= gen_source_req; // stuck-high input defeats the switch
    end else if (src_failed || (clock_switched_flag && any_fail)) begin
      gen_source <= ocfd_pkg::SEL_SAFE;
    end else begin
      gen_source <= gen_source_req; // firmware reroute after failure
    end
  end
endmodule : ocfd_top

//--- verification/ocfd_top_chk.sv
`timescale 1ns/10ps
// ==========
// status checks
module ocfd_top_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // enables
  input wire logic hf_osc_enable,
  input wire logic hf_detector_enable,
  input wire logic lf_osc_enable,
  input wire logic lf_detector_enable,
  // status
  input wire logic clock_fail_flag,
  input wire logic clock_switched_flag,
  input wire logic hf_osc_fail_flag,
  input wire logic hf_osc_ready_flag,
  input wire logic lf_osc_fail_flag,
  input wire logic [1:0] gen_source
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  AST_HF_READY: assert property ($rose(hf_osc_fail_flag) |-> hf_osc_ready_flag)
    else $error("fast ready low on failure");
  AST_SW_SAFE: assert property ($rose(clock_switched_flag) |-> gen_source == ocfd_pkg::SEL_SAFE)
    else $error("switched without safe source");
  AST_SW_FAIL: assert property (clock_switched_flag |-> clock_fail_flag || $past(clock_fail_flag))
    else $error("switched without failure");
  AST_HF_CLR: assert property (!hf_osc_enable && !hf_detector_enable |-> ##[1:4] !hf_osc_fail_flag)
    else $error("fast failure not cleared");
  AST_LF_CLR: assert property (!lf_osc_enable && !lf_detector_enable |-> ##[1:4] !lf_osc_fail_flag)
    else $error("slow failure not cleared");
endmodule : ocfd_top_chk

//--- verification/ocfd_top_tb.sv
`timescale 1ns/10ps
// ==========
// bench
module ocfd_top_tb;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic hf_osc_enable = 1'h0;
  logic hf_detector_enable = 1'h0;
  logic main_crystal_oscillator = 1'h0;
  logic lf_osc_enable = 1'h0;
  logic lf_detector_enable = 1'h0;
  logic low_freq_crystal_oscillator = 1'h0;
  logic [1:0] gen_source_req = 2'h0;
  logic clock_fail_flag, clock_switched_flag, hf_osc_fail_flag, hf_osc_ready_flag, lf_osc_fail_flag;
  logic [1:0] gen_source;
  logic hf_tog = 1'h0;
  logic hf_lvl = 1'h0;
  logic lf_tog = 1'h0;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  ocfd_top u_dut (.*);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // oscillator pins: toggling or held
  always @(negedge sys_clk) begin
    main_crystal_oscillator <= hf_tog ? ~main_crystal_oscillator : hf_lvl;
    low_freq_crystal_oscillator <= lf_tog ? ~low_freq_crystal_oscillator : 1'h0;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_fail(input int n);
    while (n > 0 && clock_fail_flag !== 1'h1) begin
      n--;
      @(negedge sys_clk);
    end
    cyc(3);
  endtask : wait_fail
  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    cyc(2);
    rst_b = 1'h1;
    chk("fail", clock_fail_flag, 2'h0);
    hf_tog = 1'h1;
    hf_detector_enable = 1'h1;
    hf_osc_enable = 1'h1;
    cyc(40);
    chk("hf_fail", hf_osc_fail_flag, 2'h0);
    hf_tog = 1'h0;
    wait_fail(40);
    chk("hf_fail", hf_osc_fail_flag, 2'h1);
    chk("hf_ready", hf_osc_ready_flag, 2'h1);
    chk("switched", clock_switched_flag, 2'h1);
    chk("source", gen_source, ocfd_pkg::SEL_SAFE);
    // re-arm: oscillator off, detector off, detector on, oscillator on
    hf_osc_enable = 1'h0;
    hf_detector_enable = 1'h0;
    cyc(4);
    chk("hf_fail", hf_osc_fail_flag, 2'h0);
    hf_detector_enable = 1'h1;
    hf_tog = 1'h1;
    hf_osc_enable = 1'h1;
    cyc(40);
    chk("hf_fail", hf_osc_fail_flag, 2'h0);
    // detector toggled while the oscillator runs
    hf_detector_enable = 1'h0;
    cyc(1);
    hf_detector_enable = 1'h1;
    cyc(4);
    chk("hf_false_fail", hf_osc_fail_flag, 2'h1);
    hf_osc_enable = 1'h0;
    hf_detector_enable = 1'h0;
    cyc(4);
    hf_detector_enable = 1'h1;
    cyc(1);
    hf_osc_enable = 1'h1;
    cyc(40);
    chk("hf_fail", hf_osc_fail_flag, 2'h0);
    hf_tog = 1'h0;
    hf_lvl = 1'h1;
    wait_fail(60);
    chk("fail", clock_fail_flag, 2'h1);
    chk("switched", clock_switched_flag, 2'h0);
    chk("source", gen_source, ocfd_pkg::SEL_HF);
    gen_source_req = ocfd_pkg::SEL_SAFE;
    cyc(3);
    chk("source", gen_source, ocfd_pkg::SEL_SAFE);
    hf_osc_enable = 1'h0;
    hf_detector_enable = 1'h0;
    cyc(4);
    // watchdog reset, then firmware keeps the safe source
    rst_b = 1'h0;
    cyc(2);
    rst_b = 1'h1;
    cyc(2);
    chk("source", gen_source, ocfd_pkg::SEL_SAFE);
    chk("fail", clock_fail_flag, 2'h0);
    gen_source_req = ocfd_pkg::SEL_LF;
    lf_tog = 1'h1;
    lf_detector_enable = 1'h1;
    lf_osc_enable = 1'h1;
    cyc(40);
    chk("lf_fail", lf_osc_fail_flag, 2'h0);
    lf_tog = 1'h0;
    wait_fail(400);
    chk("lf_fail", lf_osc_fail_flag, 2'h1);
    chk("source", gen_source, ocfd_pkg::SEL_SAFE);
    lf_osc_enable = 1'h0;
    lf_detector_enable = 1'h0;
    cyc(4);
    chk("lf_fail", lf_osc_fail_flag, 2'h0);
    lf_detector_enable = 1'h1;
    cyc(1);
    lf_tog = 1'h1;
    lf_osc_enable = 1'h1;
    cyc(40);
    chk("lf_fail", lf_osc_fail_flag, 2'h0);
    lf_detector_enable = 1'h0;
    cyc(1);
    lf_detector_enable = 1'h1;
    cyc(4);
    chk("lf_false_fail", lf_osc_fail_flag, 2'h1);
    lf_osc_enable = 1'h0;
    lf_detector_enable = 1'h0;
    cyc(4);
    chk("lf_fail", lf_osc_fail_flag, 2'h0);
    tally_and_finish();
  end
endmodule : ocfd_top_tb
bind ocfd_top ocfd_top_chk u_chk (.*);
